// ### cfsp_flags_stack.sv
`timescale 1ns/10ps
module cfsp_flags_stack
    import cfsp_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire cfsp_pkg::cfsp_alu_t        aluIn,
    input  wire cfsp_pkg::cfsp_branch_req_t branchReq,
    input  wire cfsp_pkg::cfsp_stack_req_t  stackReq,
    input  wire cfsp_pkg::cfsp_ctx_req_t    ctxReq,
    output cfsp_pkg::cfsp_flags_t           flags_ff,
    output logic                            branchDone_ff,
    output logic                            branchTaken_ff,
    output logic [15:0]                     stackPointer_ff,
    output logic [cfsp_pkg::DATA_W-1:0]     popData,
    output logic                            popValid_ff,
    output logic                            ctxBusy_ff
);
    import cfsp_pkg::*;

    cfsp_flags_t        nxt_flags;
    logic               nxt_branchDone;
    logic               nxt_branchTaken;
    logic [OFS_W-1:0]   offset_ff;
    logic [OFS_W-1:0]   nxt_offset;
    cfsp_seq_t          seqState_ff;
    cfsp_seq_t          nxt_seqState;
    logic [CTX_W-1:0]   ctxBytes_ff;
    logic [CTX_W-1:0]   nxt_ctxBytes;
    logic [2:0]         ctxLeft_ff;
    logic [2:0]         nxt_ctxLeft;
    logic               ramWe;
    logic [OFS_W-1:0]   ramWaddr;
    logic [DATA_W-1:0]  ramWdata;
    logic               ramRe;
    logic [OFS_W-1:0]   ramRaddr;

    function automatic logic [1:0] signZero(input logic [DATA_W-1:0] res);
        signZero = {res[DATA_W-1], (res == '0)};
    endfunction

    function automatic logic branchHolds(input cfsp_branch_t cond, input cfsp_flags_t f);
        logic hit;
        hit = 1'b0;
        unique case (cond)
            BR_IF_MINUS:       hit = f.n;
            BR_IF_PLUS:        hit = !f.n;
            BR_IF_EQUAL:       hit = f.z;
            BR_IF_NOT_EQUAL:   hit = !f.z;
            BR_ON_OVERFLOW:    hit = f.c;
            BR_ON_NO_OVERFLOW: hit = !f.c;
            default:           hit = 1'b0;
        endcase
        branchHolds = hit;
    endfunction

    // Natural 7-bit wrap gives the silent stack wrap at both ends
    function automatic logic [OFS_W-1:0] stepOfs(input logic [OFS_W-1:0] ofs, input logic up);
        stepOfs = up ? ofs + OFS_STEP : ofs - OFS_STEP; // [RULE_11]
    endfunction

    always_comb
    begin
        nxt_flags = flags_ff;
        unique case (aluIn.cmd)
            FC_NONE:
            begin
            end
            FC_ARITH:
            begin
                {nxt_flags.n, nxt_flags.z} = signZero(aluIn.result); // [RULE_01] [RULE_02]
                nxt_flags.c = aluIn.carry; // [RULE_03]
            end
            FC_LOGIC:
            begin
                {nxt_flags.n, nxt_flags.z} = signZero(aluIn.result); // [RULE_01] [RULE_02]
            end
            FC_BIT_TEST:
            begin
                nxt_flags.c = aluIn.carry; // [RULE_04]
            end
            FC_SHIFT:
            begin
                {nxt_flags.n, nxt_flags.z} = signZero(aluIn.result);
                nxt_flags.c = aluIn.carry; // [RULE_04]
            end
            FC_SET_OVF:
            begin
                nxt_flags.c = 1'b1; // [RULE_03]
            end
            FC_CLR_OVF:
            begin
                nxt_flags.c = 1'b0; // [RULE_03]
            end
            default:
            begin
            end
        endcase
    end

    always_comb
    begin
        nxt_branchDone  = branchReq.valid;
        nxt_branchTaken = branchReq.valid && branchHolds(branchReq.cond, flags_ff); // [RULE_05]
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_ff       <= cfsp_flags_t'(FLAGS_RESET);
            branchDone_ff  <= 1'b0;
            branchTaken_ff <= 1'b0;
        end
        else
        begin
            flags_ff       <= nxt_flags;
            branchDone_ff  <= nxt_branchDone;
            branchTaken_ff <= nxt_branchTaken;
        end
    end

    // A context frame wins over a stack command in the same cycle; the command is dropped
    always_comb
    begin
        nxt_offset   = offset_ff;
        nxt_seqState = seqState_ff;
        nxt_ctxBytes = ctxBytes_ff;
        nxt_ctxLeft  = ctxLeft_ff;
        ramWe        = 1'b0;
        ramWaddr     = offset_ff;
        ramWdata     = '0;
        ramRe        = 1'b0;
        ramRaddr     = offset_ff;
        unique case (seqState_ff)
            SEQ_IDLE:
            begin
                if (ctxReq.valid && (ctxReq.count != 3'h0))
                begin
                    nxt_seqState = SEQ_SAVE; // [RULE_12]
                    nxt_ctxBytes = ctxReq.bytes;
                    nxt_ctxLeft  = (ctxReq.count > CTX_CNT_MAX) ? CTX_CNT_MAX : ctxReq.count;
                end
                else
                begin
                    unique case (stackReq.cmd)
                        SC_NONE:
                        begin
                        end
                        SC_PUSH:
                        begin
                            ramWe      = 1'b1; // [RULE_12]
                            ramWdata   = stackReq.data;
                            nxt_offset = stepOfs(offset_ff, 1'b0); // [RULE_08]
                        end
                        SC_POP:
                        begin
                            nxt_offset = stepOfs(offset_ff, 1'b1); // [RULE_08]
                            ramRe      = 1'b1;
                            ramRaddr   = nxt_offset;
                        end
                        SC_RESET_SP:
                        begin
                            nxt_offset = OFS_TOP; // [RULE_07]
                        end
                        SC_LOAD_LOW:
                        begin
                            // Bit 7 and the high byte are fixed, so only the offset is taken
                            nxt_offset = stackReq.data[OFS_W-1:0]; // [RULE_10] [RULE_13]
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            SEQ_SAVE:
            begin
                ramWe        = 1'b1; // [RULE_12]
                ramWdata     = ctxBytes_ff[DATA_W-1:0];
                nxt_offset   = stepOfs(offset_ff, 1'b0); // [RULE_08]
                nxt_ctxBytes = ctxBytes_ff >> DATA_W;
                nxt_ctxLeft  = ctxLeft_ff - 3'h1;
                if (ctxLeft_ff == 3'h1)
                begin
                    nxt_seqState = SEQ_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            offset_ff       <= OFS_TOP;
            stackPointer_ff <= SP_RESET; // [RULE_07]
            seqState_ff     <= SEQ_IDLE;
            ctxBytes_ff     <= '0;
            ctxLeft_ff      <= 3'h0;
            ctxBusy_ff      <= 1'b0;
            popValid_ff     <= 1'b0;
        end
        else
        begin
            offset_ff       <= nxt_offset;
            stackPointer_ff <= {SP_FORCED, nxt_offset}; // [RULE_06] [RULE_09]
            seqState_ff     <= nxt_seqState;
            ctxBytes_ff     <= nxt_ctxBytes;
            ctxLeft_ff      <= nxt_ctxLeft;
            ctxBusy_ff      <= (nxt_seqState == SEQ_SAVE);
            popValid_ff     <= ramRe;
        end
    end

    cfsp_stack_ram u_ram (
        .core_clk  (core_clk),
        .rst       (rst),
        .wrEn      (ramWe),
        .wrAddr    (ramWaddr),
        .wrData    (ramWdata),
        .rdEn      (ramRe),
        .rdAddr    (ramRaddr),
        .rdData_ff (popData)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wire idleCmd = (seqState_ff == SEQ_IDLE) && !(ctxReq.valid && (ctxReq.count != 3'h0));

    negFlag_a: assert property ((aluIn.cmd inside {FC_ARITH, FC_LOGIC, FC_SHIFT}) |=> // [RULE_01]
        (flags_ff[FLAG_N_POS] == $past(aluIn.result[DATA_W-1]))) else $error("negative flag wrong");
    zeroFlag_a: assert property ((aluIn.cmd inside {FC_ARITH, FC_LOGIC, FC_SHIFT}) |=> // [RULE_02]
        (flags_ff[FLAG_Z_POS] == ($past(aluIn.result) == '0))) else $error("zero flag wrong");
    carrySet_a: assert property ((aluIn.cmd == FC_SET_OVF) |=> flags_ff[FLAG_C_POS] // [RULE_03]
        ##0 (flags_ff.n == $past(flags_ff.n))) else $error("set carry failed");
    carryClr_a: assert property ((aluIn.cmd == FC_CLR_OVF) |=> !flags_ff.c) else $error("clear carry failed"); // [RULE_03]
    bitTest_a: assert property ((aluIn.cmd == FC_BIT_TEST) |=> (flags_ff.c == $past(aluIn.carry)) // [RULE_04]
        && $stable(flags_ff.z) && $stable(flags_ff.n)) else $error("bit test flags wrong");
    branchMinus_a: assert property ((branchReq.valid && branchReq.cond == BR_IF_MINUS) |=> // [RULE_05]
        branchDone_ff && (branchTaken_ff == $past(flags_ff.n))) else $error("minus branch wrong");
    branchNoOvf_a: assert property ((branchReq.valid && branchReq.cond == BR_ON_NO_OVERFLOW) |=> // [RULE_05]
        (branchTaken_ff == !$past(flags_ff.c))) else $error("no carry branch wrong");
    forcedBits_a: assert property (stackPointer_ff[15:OFS_W] == SP_FORCED) else $error("forced bits moved"); // [RULE_09]
    resetSp_a: assert property ((idleCmd && stackReq.cmd == SC_RESET_SP) |=> // [RULE_07]
        (stackPointer_ff == SP_RESET)) else $error("stack reset wrong");
    loadLow_a: assert property ((idleCmd && stackReq.cmd == SC_LOAD_LOW) |=> // [RULE_13]
        (stackPointer_ff == {SP_FORCED, $past(stackReq.data[OFS_W-1:0])})) else $error("load low wrong");
    pushDec_a: assert property ((idleCmd && stackReq.cmd == SC_PUSH) |-> ramWe && (ramWaddr == offset_ff) // [RULE_08]
        ##1 (offset_ff == 7'($past(offset_ff) - OFS_STEP))) else $error("push step wrong");
    popInc_a: assert property ((idleCmd && stackReq.cmd == SC_POP) |-> (ramRaddr == 7'(offset_ff + OFS_STEP)) // [RULE_08]
        ##1 popValid_ff) else $error("pop step wrong");
    pushWrap_a: assert property ((idleCmd && stackReq.cmd == SC_PUSH && offset_ff == '0) |=> // [RULE_11]
        (offset_ff == OFS_TOP)) else $error("push wrap wrong");
    ctxSave_a: assert property ((idleCmd == 1'b0 && seqState_ff == SEQ_IDLE && ctxReq.count == CTX_CNT_MAX) |=> // [RULE_12]
        ctxBusy_ff [*5] ##1 (!ctxBusy_ff && (stackPointer_ff[OFS_W-1:0] ==
        7'($past(stackPointer_ff[OFS_W-1:0], 6) - 7'h05)))) else $error("context save wrong");

    wrapCover_c: cover property (idleCmd && stackReq.cmd == SC_PUSH && offset_ff == '0);
    ctxCover_c: cover property (ctxBusy_ff ##1 !ctxBusy_ff);
    takenCover_c: cover property (branchTaken_ff);
    popCover_c: cover property (popValid_ff);
endmodule

// ### cfsp_flags_stack_bench.sv
`timescale 1ns/10ps
module cfsp_flags_stack_bench;
    import cfsp_pkg::*;

    logic             core_clk;
    logic             rst;
    cfsp_alu_t        aluIn;
    cfsp_branch_req_t branchReq;
    cfsp_stack_req_t  stackReq;
    cfsp_ctx_req_t    ctxReq;
    cfsp_flags_t      flags_ff;
    logic             branchDone_ff;
    logic             branchTaken_ff;
    logic [15:0]      stackPointer_ff;
    logic [7:0]       popData;
    logic             popValid_ff;
    logic             ctxBusy_ff;
    int               errorCnt;
    int               numChecks;

    cfsp_flags_stack u_dut (
        .core_clk        (core_clk),
        .rst             (rst),
        .aluIn           (aluIn),
        .branchReq       (branchReq),
        .stackReq        (stackReq),
        .ctxReq          (ctxReq),
        .flags_ff        (flags_ff),
        .branchDone_ff   (branchDone_ff),
        .branchTaken_ff  (branchTaken_ff),
        .stackPointer_ff (stackPointer_ff),
        .popData         (popData),
        .popValid_ff     (popValid_ff),
        .ctxBusy_ff      (ctxBusy_ff)
    );

    always #10 core_clk = ~core_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        numChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic alu(input cfsp_flag_cmd_t c, input logic [7:0] r, input logic cy, input logic [2:0] exp);
        @(posedge core_clk);
        aluIn <= '{cmd: c, result: r, carry: cy};
        @(posedge core_clk);
        aluIn <= '{cmd: FC_NONE, result: 8'h00, carry: 1'b0};
        #1;
        chk(16'(flags_ff), 16'(exp), "flags");
    endtask

    task automatic stk(input cfsp_stack_cmd_t c, input logic [7:0] d, input logic [15:0] sp, input logic [7:0] pd);
        @(posedge core_clk);
        stackReq <= '{cmd: c, data: d};
        @(posedge core_clk);
        stackReq <= '{cmd: SC_NONE, data: 8'h00};
        #1;
        chk(stackPointer_ff, sp, "stack pointer");
        chk(16'(popValid_ff), 16'(c == SC_POP), "pop valid");
        if (c == SC_POP)
            chk(16'(popData), 16'(pd), "pop data");
    endtask

    // Expected outcome worked out from the flag image {n,z,c}
    function automatic logic wantTaken(input logic [2:0] f, input int c);
        case (c)
            0:       return f[2];
            1:       return !f[2];
            2:       return f[1];
            3:       return !f[1];
            4:       return f[0];
            default: return !f[0];
        endcase
    endfunction

    task automatic branchAll(input logic [2:0] f);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            branchReq <= '{valid: 1'b1, cond: cfsp_branch_t'(3'(i))};
            @(posedge core_clk);
            branchReq <= '{valid: 1'b0, cond: BR_IF_MINUS};
            #1;
            chk(16'(branchDone_ff), 16'h0001, "branch done");
            chk(16'(branchTaken_ff), 16'(wantTaken(f, i)), "branch taken");
        end
    endtask

    task automatic test_flags;
        alu(FC_ARITH, 8'h80, 1'b1, 3'b101);
        alu(FC_ARITH, 8'h00, 1'b0, 3'b010);
        alu(FC_LOGIC, 8'h81, 1'b1, 3'b100);
        alu(FC_SET_OVF, 8'h00, 1'b0, 3'b101);
        alu(FC_LOGIC, 8'h00, 1'b0, 3'b011);
        alu(FC_BIT_TEST, 8'h80, 1'b0, 3'b010);
        alu(FC_SHIFT, 8'h40, 1'b1, 3'b001);
        alu(FC_CLR_OVF, 8'hFF, 1'b1, 3'b000);
        $display("test flags done");
    endtask

    task automatic test_branch;
        alu(FC_ARITH, 8'h80, 1'b1, 3'b101);
        branchAll(3'b101);
        alu(FC_ARITH, 8'h00, 1'b0, 3'b010);
        branchAll(3'b010);
        $display("test branch done");
    endtask

    task automatic test_push_pop;
        stk(SC_PUSH, 8'hAA, 16'h017E, 8'h00);
        stk(SC_PUSH, 8'h55, 16'h017D, 8'h00);
        stk(SC_POP, 8'h00, 16'h017E, 8'h55);
        stk(SC_POP, 8'h00, 16'h017F, 8'hAA);
        $display("test push pop done");
    endtask

    task automatic test_wrap_load;
        stk(SC_LOAD_LOW, 8'h00, 16'h0100, 8'h00);
        stk(SC_PUSH, 8'h77, 16'h017F, 8'h00);
        stk(SC_POP, 8'h00, 16'h0100, 8'h77);
        stk(SC_LOAD_LOW, 8'h85, 16'h0105, 8'h00);
        stk(SC_RESET_SP, 8'h00, 16'h017F, 8'h00);
        stk(SC_LOAD_LOW, 8'h2A, 16'h012A, 8'h00);
        stk(SC_LOAD_LOW, 8'hFF, 16'h017F, 8'h00);
        $display("test wrap load done");
    endtask

    // Frame of up to five bytes; a count above five clamps, so both runs push the same five bytes
    task automatic ctxFrame(input logic [2:0] cnt);
        int waits;
        waits = 0;
        @(posedge core_clk);
        ctxReq <= '{valid: 1'b1, count: cnt, bytes: 40'h55_4433_2211};
        @(posedge core_clk);
        ctxReq <= '{valid: 1'b0, count: 3'h0, bytes: 40'h00_0000_0000};
        #1;
        while (ctxBusy_ff && waits < 8)
        begin
            @(posedge core_clk);
            #1;
            waits++;
        end
        chk(16'(waits), 16'(CTX_CNT_MAX), "ctx frame length");
        chk(stackPointer_ff, 16'h017A, "ctx frame pointer");
        stk(SC_POP, 8'h00, 16'h017B, 8'h55);
        stk(SC_RESET_SP, 8'h00, 16'h017F, 8'h00);
    endtask

    task automatic test_ctx;
        @(posedge core_clk);
        ctxReq <= '{valid: 1'b1, count: 3'h2, bytes: 40'h00_0000_2211};
        @(posedge core_clk);
        ctxReq <= '{valid: 1'b0, count: 3'h0, bytes: 40'h00_0000_0000};
        // A push during the frame must be dropped
        stackReq <= '{cmd: SC_PUSH, data: 8'hEE};
        #1;
        chk(16'(ctxBusy_ff), 16'h0001, "ctx busy");
        @(posedge core_clk);
        stackReq <= '{cmd: SC_NONE, data: 8'h00};
        #1;
        chk(stackPointer_ff, 16'h017E, "ctx pointer");
        @(posedge core_clk);
        #1;
        chk(16'(ctxBusy_ff), 16'h0000, "ctx idle");
        chk(stackPointer_ff, 16'h017D, "ctx end pointer");
        stk(SC_POP, 8'h00, 16'h017E, 8'h22);
        stk(SC_POP, 8'h00, 16'h017F, 8'h11);
        ctxFrame(3'h5);
        ctxFrame(3'h7);
        $display("test ctx done");
    endtask

    task automatic test_rearm;
        stk(SC_PUSH, 8'h33, 16'h017E, 8'h00);
        alu(FC_ARITH, 8'h80, 1'b1, 3'b101);
        @(posedge core_clk);
        rst <= 1'b1;
        #1;
        chk(stackPointer_ff, 16'h017F, "reset pointer");
        chk(16'(flags_ff), 16'h0000, "reset flags");
        @(posedge core_clk);
        rst <= 1'b0;
        // The first request right after release must be taken normally
        stk(SC_PUSH, 8'h44, 16'h017E, 8'h00);
        chk(16'(flags_ff), 16'h0000, "flags after rearm");
        $display("test rearm done");
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        errorCnt++;
        $display("[ERR] %0t run did not finish in time", $time);
        conclude();
    end

    initial
    begin
        core_clk  = 1'b0;
        rst       = 1'b1;
        errorCnt  = 0;
        numChecks = 0;
        aluIn     = '{cmd: FC_NONE, result: 8'h00, carry: 1'b0};
        branchReq = '{valid: 1'b0, cond: BR_IF_MINUS};
        stackReq  = '{cmd: SC_NONE, data: 8'h00};
        ctxReq    = '{valid: 1'b0, count: 3'h0, bytes: 40'h00_0000_0000};
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk(stackPointer_ff, 16'h017F, "pointer after reset");
        chk(16'(flags_ff), 16'h0000, "flags after reset");
        chk(16'(popValid_ff), 16'h0000, "pop valid after reset");
        test_flags();
        test_branch();
        test_push_pop();
        test_wrap_load();
        test_ctx();
        test_rearm();
        conclude();
    end
endmodule

// ### cfsp_pkg.sv
// Contract
// RULE_01 - Negative flag copies bit 7 of each arithmetic, logic or data result.
// RULE_02 - Zero flag is set when that result is zero, cleared otherwise.
// RULE_03 - Carry follows arithmetic overflow/underflow; set and clear instructions write it.
// RULE_04 - Bit-test-and-branch, shift and rotate instructions also update carry.
// RULE_05 - Branches test negative, zero or carry flag, each true and inverted.
// RULE_06 - Stack pointer is a 16-bit register addressing the next free byte.
// RULE_07 - Reset and reset-stack instruction load the pointer with 017Fh.
// RULE_08 - Decrement after each pushed byte, increment before each popped byte.
// RULE_09 - Upper nine pointer bits forced: 15..9 zero, 8 one, 7 zero.
// RULE_10 - Low pointer byte is readable and writable by the load instruction.
// RULE_11 - Pointer wraps at both stack ends without any overflow indication.
// RULE_12 - Calls and interrupts push return address or context; explicit push/pop too.
// RULE_13 - Writes to forced upper pointer bits are ignored.
package cfsp_pkg;
    localparam int          DATA_W      = 8;
    localparam int          OFS_W       = 7;
    localparam int          STACK_DEPTH = 128;
    localparam int          CTX_MAX     = 5;
    localparam int          CTX_W       = CTX_MAX * DATA_W;
    localparam logic [15:0] SP_RESET    = 16'h017F;
    localparam logic [8:0]  SP_FORCED   = 9'h002;
    localparam logic [6:0]  OFS_TOP     = 7'h7F;
    localparam logic [6:0]  OFS_STEP    = 7'h01;
    localparam logic [2:0]  CTX_CNT_MAX = 3'h5;
    localparam int          FLAG_N_POS  = 2;
    localparam int          FLAG_Z_POS  = 1;
    localparam int          FLAG_C_POS  = 0;
    localparam logic [2:0]  FLAGS_RESET = 3'h0;

    typedef enum logic [2:0] {
        FC_NONE     = 3'h0,
        FC_ARITH    = 3'h1,
        FC_LOGIC    = 3'h2,
        FC_BIT_TEST = 3'h3,
        FC_SHIFT    = 3'h4,
        FC_SET_OVF  = 3'h5,
        FC_CLR_OVF  = 3'h6
    } cfsp_flag_cmd_t;

    typedef enum logic [2:0] {
        BR_IF_MINUS       = 3'h0,
        BR_IF_PLUS        = 3'h1,
        BR_IF_EQUAL       = 3'h2,
        BR_IF_NOT_EQUAL   = 3'h3,
        BR_ON_OVERFLOW    = 3'h4,
        BR_ON_NO_OVERFLOW = 3'h5
    } cfsp_branch_t;

    typedef enum logic [2:0] {
        SC_NONE      = 3'h0,
        SC_PUSH      = 3'h1,
        SC_POP       = 3'h2,
        SC_RESET_SP  = 3'h3,
        SC_LOAD_LOW  = 3'h4
    } cfsp_stack_cmd_t;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_SAVE = 1'b1
    } cfsp_seq_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } cfsp_flags_t;

    typedef struct packed {
        cfsp_flag_cmd_t    cmd;
        logic [DATA_W-1:0] result;
        logic              carry;
    } cfsp_alu_t;

    typedef struct packed {
        logic         valid;
        cfsp_branch_t cond;
    } cfsp_branch_req_t;

    typedef struct packed {
        cfsp_stack_cmd_t   cmd;
        logic [DATA_W-1:0] data;
    } cfsp_stack_req_t;

    // Byte 0 (low bits) is pushed first, so it lands deepest and the highest pushed byte ends on top
    typedef struct packed {
        logic             valid;
        logic [2:0]       count;
        logic [CTX_W-1:0] bytes;
    } cfsp_ctx_req_t;
endpackage

// ### cfsp_stack_ram.sv
`timescale 1ns/10ps
module cfsp_stack_ram
    import cfsp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              wrEn,
    input  wire logic [OFS_W-1:0]  wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              rdEn,
    input  wire logic [OFS_W-1:0]  rdAddr,
    output logic      [DATA_W-1:0] rdData_ff
);
    logic [DATA_W-1:0] mem [STACK_DEPTH];
    logic [DATA_W-1:0] nxt_rdData;

    // Same-cycle write and read of one byte returns the old contents
    always_comb
    begin
        nxt_rdData = rdData_ff;
        if (rdEn)
        begin
            nxt_rdData = mem[rdAddr];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData_ff <= '0;
        end
        else
        begin
            rdData_ff <= nxt_rdData;
        end
    end
endmodule
